// file: hdl/dlp_core.sv
// die-link initiator low-power entry and wake handshake
`timescale 1ns/10ps
// Function
// - low-power request travels only as an ordinary link write, no extra wires
// - with no work pending, send one blocking mode-register byte write
// - WAIT/STOP executed only after the mode write is acknowledged
// - interrupts masked while checking work, re-enabled right before STOP; here masked only from ST_MASK, after the work check
// - on target interrupt, restart clock generation before the handler
// - handler clears the wake source on the target through a link write; here the core sends it itself from ST_WAKE
// - on stop, link clock finishes its high phase then parks low
// - blocking write stalls cpu until transfer and acknowledge complete
// - with stop-in-wait, pending transmission completes before clocks stop
module dlp_core
    import dlp_pkg::*;
(
    input  wire logic       sys_clk,          // system clock, 10 MHz
    input  wire logic       srst,             // synchronous reset, active high
    input  wire logic       enable,           // initiator enable
    input  wire logic       stop_in_wait_bit, // wait also waits for link clock to park
    input  wire logic       work_pending,     // cpu still has work
    input  wire logic       lp_req,           // pulse: cpu wants low power
    input  wire logic       lp_is_stop,       // 1 = stop, 0 = wait
    output logic            cpu_stall,        // cpu held by a blocking write
    output logic            cpu_irq_mask,     // cpu interrupt mask level
    output logic            cpu_sleep_q,      // cpu executing WAIT/STOP
    output logic            cpu_clk_run_q,    // cpu clock generation running
    output logic            cpu_irq_q,        // wake interrupt to cpu handler
    output logic            link_error_q,     // acknowledge missing
    output logic            link_clock_out,   // link clock to target
    output logic            link_data_out,    // serial data to target
    output logic            link_data_oe,     // link data output enable
    input  wire logic       link_data_in,     // serial data from target (async)
    input  wire logic       target_irq_line   // target interrupt, async level
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_MASK, ST_SEND, ST_ACK, ST_ARM, ST_PARK, ST_SLEEP, ST_WAKE, ST_CLR_SEND,
        ST_CLR_ACK
    } dlp_state_e;

    dlp_state_e     state_q;
    dlp_frame_s     frame_q;
    dlp_link_stat_s stat;
    logic [1:0]     irq_sync_q;
    logic [1:0]     din_sync_q;
    logic [7:0]     div_q;
    logic           lclk_q;
    logic           tick_fall;
    logic           tick_rise;
    logic           lclk_run;
    logic [4:0]     bit_q;
    logic [7:0]     rx_q;
    logic [7:0]     tmo_q;
    logic           is_stop_q;

    function automatic logic [7:0] mode_code(input logic stop);
        mode_code = stop ? MODE_CODE_STOP : MODE_CODE_WAIT;
    endfunction

    // both async inputs pass two flops before use
    always_ff @(posedge sys_clk) begin
        irq_sync_q <= {irq_sync_q[0], target_irq_line};
        din_sync_q <= {din_sync_q[0], link_data_in};
    end

    // clock runs only while a frame or acknowledge is in flight
    assign lclk_run = (state_q == ST_SEND) || (state_q == ST_ACK) ||
                      (state_q == ST_CLR_SEND) || (state_q == ST_CLR_ACK);
    assign tick_fall = (div_q == 8'(LINK_HALF_CYC - 1)) && lclk_q;
    assign tick_rise = (div_q == 8'(LINK_HALF_CYC - 1)) && !lclk_q && lclk_run;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_q  <= 8'h00;
            lclk_q <= 1'b0;
        end else if (lclk_q || lclk_run) begin
            // a high phase always completes, so the clock parks only at low
            if (div_q == 8'(LINK_HALF_CYC - 1)) begin
                div_q  <= 8'h00;
                lclk_q <= ~lclk_q;
            end else begin
                div_q <= div_q + 8'h01;
            end
        end else begin
            div_q <= 8'h00;
        end
    end
    assign link_clock_out = lclk_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            is_stop_q <= 1'b0;
        end else if (lp_req && state_q == ST_IDLE) begin
            is_stop_q <= lp_is_stop;
        end
    end

    // mode request sent as a link write
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            frame_q <= '0;
        end else if (state_q == ST_MASK) begin
            frame_q <= '{addr: MODE_REG_ADDR, data: mode_code(is_stop_q)};
        end else if (state_q == ST_WAKE) begin
            frame_q <= '{addr: IRQ_CLR_ADDR, data: IRQ_CLR_VALUE};
        end
    end

    // serial shift: data launched on falling edge, msb first
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bit_q <= 5'h00;
        end else if (state_q == ST_MASK || state_q == ST_WAKE) begin
            bit_q <= 5'h00;
        end else if ((state_q == ST_SEND || state_q == ST_CLR_SEND) && tick_fall) begin
            bit_q <= bit_q + 5'h01;
        end else if ((state_q == ST_ACK || state_q == ST_CLR_ACK) && tick_rise) begin
            bit_q <= bit_q + 5'h01;
        end else if (bit_q == FRAME_BITS_W && (state_q == ST_ACK || state_q == ST_CLR_ACK)) begin
            bit_q <= bit_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link_data_out <= 1'b0;
            link_data_oe  <= 1'b0;
        end else if ((state_q == ST_SEND || state_q == ST_CLR_SEND) && bit_q < FRAME_BITS_W) begin
            link_data_out <= frame_q[4'(FRAME_BITS - 1) - bit_q[3:0]];
            link_data_oe  <= 1'b1;
        end else begin
            link_data_out <= 1'b0;
            link_data_oe  <= 1'b0;
        end
    end

    // sample acknowledge symbol on rising edges
    always_ff @(posedge sys_clk) begin
        if (srst || state_q == ST_SEND || state_q == ST_CLR_SEND) begin
            rx_q  <= 8'h00;
            tmo_q <= 8'h00;
        end else if ((state_q == ST_ACK || state_q == ST_CLR_ACK) && tick_rise) begin
            rx_q  <= {rx_q[6:0], din_sync_q[1]};
            tmo_q <= tmo_q + 8'h01;
        end
    end

    assign stat.busy    = lclk_run;
    assign stat.acked   = (rx_q == ACK_SYMBOL);
    assign stat.timeout = (tmo_q == 8'(ACK_TIMEOUT_CYC));

    always_ff @(posedge sys_clk) begin
        if (srst || state_q == ST_MASK) begin
            link_error_q <= 1'b0;
        end else if (stat.timeout && stat.busy) begin
            link_error_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !enable) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: if (lp_req && !work_pending) begin
                    state_q <= ST_MASK;
                end
                ST_MASK: state_q <= ST_SEND;
                ST_SEND: if (tick_fall && bit_q == FRAME_BITS_W - 5'h01) begin
                    state_q <= ST_ACK;
                end
                ST_ACK: if (stat.acked) begin
                    state_q <= ST_ARM;
                end else if (stat.timeout) begin
                    state_q <= ST_IDLE;
                end
                // wait-mode without stop bit enters sleep without waiting for the link clock to park
                ST_ARM: state_q <= (is_stop_q || stop_in_wait_bit) ? ST_PARK : ST_SLEEP;
                ST_PARK: if (!lclk_q) begin
                    state_q <= ST_SLEEP;
                end
                ST_SLEEP: if (irq_sync_q[1]) begin
                    state_q <= ST_WAKE;
                end
                ST_WAKE: state_q <= ST_CLR_SEND;
                ST_CLR_SEND: if (tick_fall && bit_q == FRAME_BITS_W - 5'h01) begin
                    state_q <= ST_CLR_ACK;
                end
                ST_CLR_ACK: if (stat.acked || stat.timeout) begin
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign cpu_stall = (state_q == ST_MASK) || (state_q == ST_SEND) || (state_q == ST_ACK);
    // mask during mode write and acknowledge, clear before sleep
    assign cpu_irq_mask = cpu_stall;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpu_sleep_q   <= 1'b0;
            cpu_clk_run_q <= 1'b1;
            cpu_irq_q     <= 1'b0;
        end else begin
            cpu_sleep_q   <= (state_q == ST_PARK) || (state_q == ST_SLEEP);
            cpu_clk_run_q <= !((state_q == ST_SLEEP) && is_stop_q);
            cpu_irq_q     <= irq_sync_q[1] && (state_q != ST_SLEEP);
        end
    end
endmodule

// file: inc/dlp_pkg.sv
// package: constants and types for the die-link low-power handshake block
package dlp_pkg;
    // link clock divider: half period of link_clock_out in sys_clk cycles
    localparam int unsigned LINK_HALF_NS     = 400;
    localparam int unsigned SYS_CLK_NS       = 100;
    localparam int unsigned LINK_HALF_CYC    = (LINK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    // acknowledge timeout in link clock periods
    localparam int unsigned ACK_TIMEOUT_CYC  = 64;
    // frame length in bits: 8 address + 8 data
    localparam int unsigned FRAME_BITS       = 16;
    localparam logic [4:0]  FRAME_BITS_W     = 5'h10;
    localparam logic [7:0]  ACK_SYMBOL       = 8'ha5;
    // target-side addresses
    localparam logic [7:0]  MODE_REG_ADDR    = 8'h00;
    localparam logic [7:0]  IRQ_CLR_ADDR     = 8'h01;
    localparam logic [7:0]  IRQ_CLR_VALUE    = 8'h01;
    // low-power mode codes written to the target
    localparam logic [7:0]  MODE_CODE_WAIT   = 8'h01;
    localparam logic [7:0]  MODE_CODE_STOP   = 8'h02;

    typedef enum logic [1:0] {
        DLP_LP_WAIT,
        DLP_LP_STOP,
        DLP_LP_NONE
    } dlp_lp_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } dlp_frame_s;

    typedef struct packed {
        logic busy;
        logic acked;
        logic timeout;
    } dlp_link_stat_s;
endpackage

// file: verif/die_link_low_power_handshake_tb.sv
// testbench: entry, wake, refusal, timeout and reset of the handshake core
`timescale 1ns/10ps
module die_link_low_power_handshake_tb;
    import dlp_pkg::*;
    logic sys_clk = 0, srst = 1, enable = 0, swai = 0, work = 0, lp_req = 0, is_stop = 0;
    logic ack_en = 1, wake = 0;
    logic stall, mask, sleep, clk_run, irq, err, lclk, ldo, loe, ldi, tirq;
    dlp_frame_s frm;
    int n_fr, n_errors = 0, tests_run = 0;
    dlp_core i_dlp_core (.sys_clk(sys_clk), .srst(srst), .enable(enable),
        .stop_in_wait_bit(swai), .work_pending(work), .lp_req(lp_req), .lp_is_stop(is_stop),
        .cpu_stall(stall), .cpu_irq_mask(mask), .cpu_sleep_q(sleep), .cpu_clk_run_q(clk_run),
        .cpu_irq_q(irq), .link_error_q(err), .link_clock_out(lclk), .link_data_out(ldo),
        .link_data_oe(loe), .link_data_in(ldi), .target_irq_line(tirq));
    dlp_target_model i_dlp_target_model (.link_clock_out(lclk), .link_data_out(ldo),
        .srst(srst), .ack_en(ack_en), .wake(wake), .link_data_in(ldi),
        .target_irq_line(tirq), .last_frame(frm), .n_frames(n_fr));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task final_report;
        if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        int k;
        for (k = 0; k < lim && s !== v; k++) @(posedge sys_clk);
        #1;
        check("wait", s, v);
        if (s !== v) final_report();
    endtask
    task pulse_req;
        @(posedge sys_clk) lp_req <= 1'b1;
        @(posedge sys_clk) lp_req <= 1'b0;
        #1;
    endtask
    task t_enter(input logic stp, input logic sw);
        int n0;
        n0 = n_fr;
        swai <= sw;
        is_stop <= stp;
        pulse_req();
        check("stall", stall, 1'b1);
        check("mask", mask, 1'b1);
        wait_sig(stall, 1'b0, 1000);
        check("mode", frm, {MODE_REG_ADDR, stp ? MODE_CODE_STOP : MODE_CODE_WAIT});
        check("one frame", n_fr - n0, 1);
        wait_sig(sleep, 1'b1, 20);
        check("unmask", mask, 1'b0);
        // the link clock may finish its high phase and stop only after sleep begins
        repeat (20) @(posedge sys_clk);
        #1;
        check("clk run", clk_run, !stp);
        check("park", lclk, 1'b0);
        check("quiet", n_fr - n0, 1);
        wake <= 1'b1;
        wait_sig(sleep, 1'b0, 20);
        check("restart", clk_run, 1'b1);
        check("irq", irq, 1'b1);
        wait_sig(tirq, 1'b0, 1000);
        check("clear", frm, {IRQ_CLR_ADDR, IRQ_CLR_VALUE});
        wake <= 1'b0;
        wait_sig(irq, 1'b0, 10);
        // the clear write still awaits its acknowledge; a request now would be refused
        repeat (80) @(posedge sys_clk);
        #1;
        check("clr parked", lclk, 1'b0);
    endtask
    task t_refuse;
        work <= 1'b1;
        pulse_req();
        repeat (3) @(posedge sys_clk);
        check("work refuse", stall, 1'b0);
        work <= 1'b0;
        enable <= 1'b0;
        pulse_req();
        @(posedge sys_clk) enable <= 1'b1;
        #1;
        check("off refuse", stall, 1'b0);
    endtask
    task t_reset_mid;
        pulse_req();
        repeat (40) @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk) srst <= 1'b0;
        #1;
        check("rst idle", {stall, lclk, loe, sleep}, 4'h0);
    endtask
    task t_nack;
        ack_en <= 1'b0;
        pulse_req();
        wait_sig(stall, 1'b0, 1000);
        check("timeout", {err, sleep}, 2'h2);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        enable <= 1'b1;
        t_refuse();
        t_enter(1'b1, 1'b0);
        t_enter(1'b0, 1'b1);
        t_enter(1'b0, 1'b0);
        t_reset_mid();
        t_enter(1'b1, 1'b1);
        t_nack();
        final_report();
    end
endmodule

// file: verif/dlp_core_chk.sv
// checker: port-level assertions for the low-power handshake core
`timescale 1ns/10ps
module dlp_core_chk (
    input wire logic sys_clk, srst, enable, stop_in_wait_bit, work_pending, lp_req, lp_is_stop,
    input wire logic cpu_stall, cpu_irq_mask, cpu_sleep_q, cpu_clk_run_q, cpu_irq_q,
    input wire logic link_error_q, link_clock_out, link_data_out, link_data_oe,
    input wire logic link_data_in, target_irq_line
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [3:0] quiet_q;
    // low phases inside a frame last 4 cycles, so a longer low means the link is idle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            quiet_q <= 4'hf;
        end else if (link_clock_out) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    // the wake clear write runs with stall low; requests during it are refused
    sequence s_take;
        lp_req && enable && !work_pending && !cpu_stall && !cpu_sleep_q && !cpu_irq_q
            && (quiet_q > 4'h5);
    endsequence
    // frame plus 64 link clocks of ack wait fits well inside this bound
    sequence s_done;
        ##[1:1000] !cpu_stall;
    endsequence
    a_take_stall: assert property (s_take |=> cpu_stall) else $error("stall missing");
    a_stall_end: assert property ($rose(cpu_stall) |-> s_done) else $error("stall stuck");
    a_mask_stall: assert property (cpu_irq_mask == cpu_stall) else $error("mask wrong");
    a_work_refuse: assert property (lp_req && work_pending && !cpu_stall |=> !cpu_stall)
        else $error("entry taken with work");
    a_sleep_acked: assert property ($rose(cpu_sleep_q) |-> !cpu_stall)
        else $error("sleep before ack");
    // the clock may still finish its high phase just after sleep begins
    a_park_low: assert property (cpu_sleep_q && $past(cpu_sleep_q, 4) |-> !link_clock_out)
        else $error("link clock not parked");
    a_park_stays: assert property (cpu_sleep_q && !link_clock_out |=> !link_clock_out)
        else $error("link clock left park");
    a_sleep_quiet: assert property (cpu_sleep_q |-> !link_data_oe)
        else $error("link data driven asleep");
    a_clk_off: assert property (!cpu_clk_run_q |-> cpu_sleep_q) else $error("clock off awake");
    a_irq_clk: assert property (cpu_irq_q |-> cpu_clk_run_q) else $error("irq without clock");
    a_off_idle: assert property (!enable |=> !cpu_stall) else $error("busy while off");
    a_rst_idle: assert property (disable iff (1'b0) srst |=> !cpu_stall && !cpu_sleep_q
        && cpu_clk_run_q && !link_clock_out && !link_data_oe) else $error("reset not idle");
endmodule
bind dlp_core dlp_core_chk i_chk (.sys_clk(sys_clk), .srst(srst), .enable(enable),
    .stop_in_wait_bit(stop_in_wait_bit), .work_pending(work_pending), .lp_req(lp_req),
    .lp_is_stop(lp_is_stop), .cpu_stall(cpu_stall), .cpu_irq_mask(cpu_irq_mask),
    .cpu_sleep_q(cpu_sleep_q), .cpu_clk_run_q(cpu_clk_run_q), .cpu_irq_q(cpu_irq_q),
    .link_error_q(link_error_q), .link_clock_out(link_clock_out),
    .link_data_out(link_data_out), .link_data_oe(link_data_oe),
    .link_data_in(link_data_in), .target_irq_line(target_irq_line));

// file: verif/dlp_target_model.sv
// partner: behavioural target die on the far end of the link
`timescale 1ns/10ps
module dlp_target_model
    import dlp_pkg::*;
(
    input  wire logic link_clock_out,  // link clock from initiator
    input  wire logic link_data_out,   // serial data from initiator
    input  wire logic srst,            // abandon frame
    input  wire logic ack_en,          // low: never acknowledge
    input  wire logic wake,            // wake condition seen
    output logic      link_data_in,    // ack bits
    output logic      target_irq_line, // wake interrupt
    output dlp_frame_s last_frame,     // last frame received
    output int        n_frames         // frames received
);
    logic [15:0] sh = 16'h0000;
    logic        dout = 1'b0;
    logic        drv = 1'b0;
    int          nbit = 0;
    initial target_irq_line = 1'b0;
    initial n_frames = 0;
    // mode request arrives only as a framed write; reset drops it
    always @(posedge link_clock_out or posedge srst) begin
        if (srst) begin
            nbit = 0;
        end else begin
            if (nbit < 16) sh = {sh[14:0], link_data_out};
            nbit++;
            if (nbit == 16) begin
                last_frame = sh;
                n_frames++;
                // level held until the clear write lands
                if (sh == {IRQ_CLR_ADDR, IRQ_CLR_VALUE}) target_irq_line = 1'b0;
            end
            if (nbit == 24) nbit = 0;
        end
    end
    // ack msb first; sleeping early does not disturb the initiator
    always @(negedge link_clock_out) begin
        drv = ack_en && nbit >= 16 && nbit < 24;
        if (drv) dout = ACK_SYMBOL[23 - nbit];
    end
    // released line shows the inverse so a stale bit never passes
    assign link_data_in = drv ? dout : ~dout;
    // regulator leaves low power, then the line rises
    always @(posedge wake) target_irq_line = 1'b1;
endmodule
